// File: psg_consts.vh
`ifndef PSG_CONSTS_VH
`define PSG_CONSTS_VH
// register byte addresses (word aligned)
`define PSG_A_RAW_STAT 12'h050
`define PSG_A_BASE_CFG 12'h060
`define PSG_A_TRANSL 12'h064
`define PSG_A_EXT_CFG 12'h070
`define PSG_A_RUN_GATE 12'h100
`define PSG_A_SLP_GATE 12'h110
`define PSG_A_DSLP_GATE 12'h120
`define PSG_A_DSLP_CFG 12'h144
`define PSG_A_STATUS 12'h148
// reset values
`define PSG_RST_BASE_CFG 32'h07803ad1
`define PSG_RST_EXT_CFG 32'h07802810
`define PSG_RST_GATE 32'h00000040
`define PSG_RST_DSLP_CFG 32'h07800000
// base configuration fields
`define PSG_B_DIV_HI 26
`define PSG_B_DIV_LO 23
`define PSG_B_USEDIV 22
`define PSG_B_ACG 27
`define PSG_B_PWRDN 13
`define PSG_B_BYPASS 11
`define PSG_B_CRYS_HI 9
`define PSG_B_CRYS_LO 6
// crystal code held in the base configuration reset value
`define PSG_RST_CRYS 4'hb
`define PSG_B_OSC_HI 5
`define PSG_B_OSC_LO 4
// extended configuration fields
`define PSG_E_USE 31
`define PSG_E_DIV_HI 28
`define PSG_E_DIV_LO 23
`define PSG_E_PWRDN 13
`define PSG_E_BYPASS 11
`define PSG_E_OSC_HI 6
`define PSG_E_OSC_LO 4
// deep-sleep configuration fields
`define PSG_D_DIV_HI 28
`define PSG_D_DIV_LO 23
`define PSG_D_OSC_HI 6
`define PSG_D_OSC_LO 4
// oscillator source codes
`define PSG_OSC_MAIN 3'h0
`define PSG_OSC_RTC 3'h7
// raw status bit and ready count
`define PSG_RAW_LOCK 6
`define PSG_READY_COUNT 13'h1200
`endif

// File: psg_clock_ctrl.v
// Our own choices: the placing of the registers and register access over Avalon-MM.
`default_nettype none
`include "psg_consts.vh"

// Overview of operation
// - six-bit extended divider, divide by encoding plus one, up to /64.
// - pll source halved from 400 MHz before the system divider.
// - divider unused and pll bypassed: system clock runs undivided.
// - crystal select translated into pll settings when main oscillator feeds pll.
// - translation readable in a read-only translation register.
// - crystal select change retranslates and relocks; same value does not.
// - extended oscillator source 0x7 selects 32 kHz rtc oscillator as reference.
// - pll disabled after reset until software enables it.
// - normal mode drives pll output; power-down mode does not.
// - power-down to normal transition starts a relock wait.
// - ready down-counter on main oscillator, loaded with 0x1200 per trigger.
// - one-step pll select keeps oscillator clocking until ready count expires.
// - lock raw flag set when ready time met; software polls it.
// - run mode clocks processor and run-gated peripherals.
// - sleep stops processor and memory clocks, keeps system clock unchanged.
// - sleep gates from sleep registers with auto gating, else run registers.
// - wait-for-irq enters sleep, deep-sleep bit selects deep; irq wakes.
// - deep sleep gates from deep-sleep registers with auto gating, else run.
// - deep sleep uses main oscillator or the selected internal oscillator.
// - deep sleep powers pll down; divider override applies only if pll was on at entry, else saved divider.
// - wake restores source and divider before re-enabling gated clocks.
// - extended use bit makes extended fields replace base fields.
module psg_clock_ctrl (
  // system
  input wire sys_clk,
  input wire rst,
  // avalon-mm slave
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // main oscillator as a sampled level
  input wire main_osc_clk,
  // processor sleep handshake
  input wire wait_irq_req,
  input wire deep_sleep_en,
  input wire irq_pending,
  // clock tree control
  output reg pll_pwr_on,
  output reg pll_out_en,
  output reg [2:0] sys_src_sel,
  output reg sys_use_pll,
  output reg sys_div_en,
  output reg [6:0] sys_divisor,
  output reg [11:0] pll_translation,
  output reg main_osc_pwr_on,
  output reg int_osc_pwr_on,
  output reg cpu_clk_en,
  output reg [31:0] periph_clk_en,
  output reg pll_locked
);

  localparam ST_RUN = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_DEEP = 2'h2;
  localparam ST_WAKE = 2'h3;

  reg [31:0] base_cfg_r, ext_cfg_r, run_gate_r, slp_gate_r, dslp_gate_r, dslp_cfg_r;
  reg [1:0] state_r;
  reg ack_r;
  reg [12:0] ready_cnt_r;
  reg cnt_run_r;
  reg [2:0] osc_sync_r;
  reg osc_level_r;
  reg pll_on_prev_r;
  reg [3:0] crys_prev_r;
  reg [2:0] save_src_r;
  reg [5:0] save_div_r;
  reg save_pll_r;

  // effective fields
  wire use_ext = ext_cfg_r[`PSG_E_USE];
  wire [2:0] eff_osc = use_ext ? ext_cfg_r[`PSG_E_OSC_HI:`PSG_E_OSC_LO] :
                       {1'b0, base_cfg_r[`PSG_B_OSC_HI:`PSG_B_OSC_LO]};
  wire eff_bypass = use_ext ? ext_cfg_r[`PSG_E_BYPASS] : base_cfg_r[`PSG_B_BYPASS];
  wire eff_pwrdn = use_ext ? ext_cfg_r[`PSG_E_PWRDN] : base_cfg_r[`PSG_B_PWRDN];
  wire [5:0] eff_div = use_ext ? ext_cfg_r[`PSG_E_DIV_HI:`PSG_E_DIV_LO] :
                       {2'h0, base_cfg_r[`PSG_B_DIV_HI:`PSG_B_DIV_LO]};
  wire use_div = base_cfg_r[`PSG_B_USEDIV];
  wire auto_gate = base_cfg_r[`PSG_B_ACG];
  wire [3:0] crys = base_cfg_r[`PSG_B_CRYS_HI:`PSG_B_CRYS_LO];
  wire pll_on = ~eff_pwrdn;
  wire [2:0] ds_osc = dslp_cfg_r[`PSG_D_OSC_HI:`PSG_D_OSC_LO];
  wire [5:0] ds_div = use_ext ? dslp_cfg_r[`PSG_D_DIV_HI:`PSG_D_DIV_LO] :
                      {2'h0, dslp_cfg_r[`PSG_D_DIV_LO+3:`PSG_D_DIV_LO]};

  // relock only on a real change
  wire crys_changed = (crys != crys_prev_r);
  wire pll_powered_up = pll_on & ~pll_on_prev_r;
  wire relock = crys_changed | pll_powered_up;

  // translation of crystal number into pll settings
  reg [11:0] transl;
  always @* begin
    // reference multiplier word and predivider derived from crystal code
    transl = {2'h0, 6'h32 - {2'h0, crys}, crys};
    // rtc reference uses its own fixed setting
    if (eff_osc == `PSG_OSC_RTC) begin
      transl = 12'hfff;
    end
  end

  // oscillator edge: stages 2 and 3 agree on a new level
  wire osc_rise = (osc_sync_r[2] == osc_sync_r[1]) & osc_sync_r[1] & ~osc_level_r;

  wire bus_rd = avs_read & ~ack_r;
  // writes land at the edge where waitrequest is seen low
  wire bus_wr = avs_write & ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0;
    case (avs_address)
      `PSG_A_RAW_STAT: rd_nxt[`PSG_RAW_LOCK] = pll_locked;
      `PSG_A_BASE_CFG: rd_nxt = base_cfg_r;
      `PSG_A_TRANSL: rd_nxt = {20'h0, pll_translation};
      `PSG_A_EXT_CFG: rd_nxt = ext_cfg_r;
      `PSG_A_RUN_GATE: rd_nxt = run_gate_r;
      `PSG_A_SLP_GATE: rd_nxt = slp_gate_r;
      `PSG_A_DSLP_GATE: rd_nxt = dslp_gate_r;
      `PSG_A_DSLP_CFG: rd_nxt = dslp_cfg_r;
      `PSG_A_STATUS: rd_nxt = {28'h0, cnt_run_r, cpu_clk_en, state_r};
      default: rd_nxt = 32'h0;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0;
      // pll held down by reset value
      base_cfg_r <= `PSG_RST_BASE_CFG;
      ext_cfg_r <= `PSG_RST_EXT_CFG;
      run_gate_r <= `PSG_RST_GATE;
      slp_gate_r <= `PSG_RST_GATE;
      dslp_gate_r <= `PSG_RST_GATE;
      dslp_cfg_r <= `PSG_RST_DSLP_CFG;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (bus_rd) begin
        avs_readdata <= rd_nxt;
      end
      if (bus_wr) begin
        case (avs_address)
          `PSG_A_BASE_CFG: base_cfg_r <= avs_writedata;
          `PSG_A_EXT_CFG: ext_cfg_r <= avs_writedata;
          `PSG_A_RUN_GATE: run_gate_r <= avs_writedata;
          `PSG_A_SLP_GATE: slp_gate_r <= avs_writedata;
          `PSG_A_DSLP_GATE: dslp_gate_r <= avs_writedata;
          `PSG_A_DSLP_CFG: dslp_cfg_r <= avs_writedata;
          default: ;
        endcase
      end
    end
  end

  // ready counter, advanced on main oscillator edges
  always @(posedge sys_clk) begin
    if (rst) begin
      osc_sync_r <= 3'h0;
      osc_level_r <= 1'b0;
      pll_on_prev_r <= 1'b0;
      // matches the reset crystal code, so release gives no false relock
      crys_prev_r <= `PSG_RST_CRYS;
      ready_cnt_r <= 13'h0;
      cnt_run_r <= 1'b0;
      pll_locked <= 1'b0;
      pll_translation <= 12'h0;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], main_osc_clk};
      if (osc_sync_r[2] == osc_sync_r[1]) begin
        osc_level_r <= osc_sync_r[2];
      end
      pll_on_prev_r <= pll_on & (state_r != ST_DEEP);
      crys_prev_r <= crys;
      pll_translation <= transl;
      if (relock) begin
        ready_cnt_r <= `PSG_READY_COUNT;
        cnt_run_r <= 1'b1;
        pll_locked <= 1'b0;
      end else if (~pll_on) begin
        cnt_run_r <= 1'b0;
        pll_locked <= 1'b0;
      end else if (cnt_run_r & osc_rise) begin
        if (ready_cnt_r == 13'h1) begin
          cnt_run_r <= 1'b0;
          pll_locked <= 1'b1;
        end
        ready_cnt_r <= ready_cnt_r - 13'h1;
      end
    end
  end

  // power-mode sequencer
  always @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_RUN;
      save_src_r <= `PSG_OSC_MAIN;
      save_div_r <= 6'h0;
      save_pll_r <= 1'b0;
    end else begin
      case (state_r)
        ST_RUN: if (wait_irq_req & ~irq_pending) begin
          state_r <= deep_sleep_en ? ST_DEEP : ST_SLEEP;
          save_src_r <= eff_osc;
          save_div_r <= eff_div;
          save_pll_r <= pll_on;
        end
        ST_SLEEP: if (irq_pending) state_r <= ST_RUN;
        ST_DEEP: if (irq_pending) state_r <= ST_WAKE;
        // one cycle with restored clocks before gates reopen
        ST_WAKE: state_r <= ST_RUN;
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // clock tree outputs
  always @(posedge sys_clk) begin
    if (rst) begin
      pll_pwr_on <= 1'b0;
      pll_out_en <= 1'b0;
      sys_src_sel <= `PSG_OSC_MAIN;
      sys_use_pll <= 1'b0;
      sys_div_en <= 1'b0;
      sys_divisor <= 7'h1;
      main_osc_pwr_on <= 1'b1;
      int_osc_pwr_on <= 1'b1;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= `PSG_RST_GATE;
    end else if (state_r == ST_DEEP) begin
      pll_pwr_on <= 1'b0;
      pll_out_en <= 1'b0;
      sys_use_pll <= 1'b0;
      sys_div_en <= 1'b1;
      sys_divisor <= {1'b0, save_pll_r ? ds_div : save_div_r} + 7'h1;
      // main oscillator unless an internal one is chosen
      sys_src_sel <= ds_osc;
      main_osc_pwr_on <= (ds_osc == `PSG_OSC_MAIN);
      int_osc_pwr_on <= (ds_osc != `PSG_OSC_MAIN);
      cpu_clk_en <= 1'b0;
      periph_clk_en <= auto_gate ? dslp_gate_r : run_gate_r;
    end else begin
      pll_pwr_on <= pll_on;
      pll_out_en <= pll_on;
      sys_src_sel <= (state_r == ST_WAKE) ? save_src_r : eff_osc;
      main_osc_pwr_on <= 1'b1;
      int_osc_pwr_on <= 1'b1;
      sys_use_pll <= ~eff_bypass & pll_on & pll_locked;
      // pll path always halved; bypass without divider is undivided
      sys_div_en <= use_div | ~eff_bypass;
      sys_divisor <= ((use_div | ~eff_bypass) ? {1'b0, eff_div} + 7'h1 : 7'h1);
      if (state_r == ST_SLEEP) begin
        cpu_clk_en <= 1'b0;
        periph_clk_en <= auto_gate ? slp_gate_r : run_gate_r;
      end else if (state_r == ST_WAKE) begin
        cpu_clk_en <= 1'b0;
        periph_clk_en <= 32'h0;
      end else begin
        cpu_clk_en <= 1'b1;
        periph_clk_en <= run_gate_r;
      end
    end
  end

endmodule // psg_clock_ctrl
`default_nettype wire

// File: psg_clock_ctrl_sva.sv
`default_nettype none
module psg_clock_ctrl_sva (
  // bus
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // sleep and clock tree
  input wire logic wait_irq_req,
  input wire logic irq_pending,
  input wire logic pll_pwr_on,
  input wire logic pll_out_en,
  input wire logic sys_use_pll,
  input wire logic [6:0] sys_divisor,
  input wire logic cpu_clk_en,
  input wire logic pll_locked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic req = avs_read | avs_write;
  sequence answered; avs_waitrequest ##1 !avs_waitrequest; endsequence
  sequence sleep_req; wait_irq_req && !irq_pending && cpu_clk_en; endsequence
  sequence wake_req; irq_pending && !cpu_clk_en; endsequence
  wait_state_a: assert property ($rose(req) |-> answered)
    else $error("bus answer not after one wait state");
  pll_reset_a: assert property ($fell(rst) |-> !pll_pwr_on)
    else $error("pll on after reset");
  pll_out_a: assert property (pll_out_en |-> pll_pwr_on)
    else $error("pll output driven while powered down");
  lock_use_a: assert property ($rose(sys_use_pll) |-> $past(pll_locked))
    else $error("pll used before lock");
  lock_pwr_a: assert property ($rose(pll_locked) |-> pll_pwr_on)
    else $error("lock flag with pll off");
  div_range_a: assert property (sys_divisor != 7'h00 && sys_divisor <= 7'h40)
    else $error("divisor out of range");
  sleep_entry_a: assert property (sleep_req |-> ##2 !cpu_clk_en)
    else $error("processor clock not stopped");
  wake_a: assert property (wake_req |-> ##[1:4] cpu_clk_en)
    else $error("no wake on interrupt");
endmodule // psg_clock_ctrl_sva
bind psg_clock_ctrl psg_clock_ctrl_sva u_psg_clock_ctrl_sva (.sys_clk, .rst, .avs_read,
  .avs_write, .avs_waitrequest, .wait_irq_req, .irq_pending, .pll_pwr_on, .pll_out_en,
  .sys_use_pll, .sys_divisor, .cpu_clk_en, .pll_locked);
`default_nettype wire

// File: test_psg_clock_ctrl.sv
`default_nettype none
`include "psg_consts.vh"
module test_psg_clock_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
  logic wait_irq_req = 0, deep_sleep_en = 0, irq_pending = 0, main_osc_clk;
  logic [1:0] osc_cnt = 2'h0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q, t0;
  logic avs_waitrequest, pll_pwr_on, pll_out_en, sys_use_pll, sys_div_en;
  logic main_osc_pwr_on, int_osc_pwr_on, cpu_clk_en, pll_locked;
  logic [2:0] sys_src_sel;
  logic [6:0] sys_divisor;
  logic [11:0] pll_translation;
  logic [31:0] periph_clk_en;
  int n_fail = 0, n_compared = 0, n;
  psg_clock_ctrl u_psg_clock_ctrl (.*);
  initial forever #50 sys_clk = ~sys_clk;
  // oscillator at a quarter of the bus clock so the synchroniser sees every edge
  always @(posedge sys_clk) osc_cnt <= osc_cnt + 2'h1;
  assign main_osc_clk = osc_cnt[1];
  task automatic summarize;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic req(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      n_fail++;
      summarize();
    end
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // the write lands at the answer edge; let the outputs follow it
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wlock;
    n = 0;
    while (pll_locked !== 1'b1 && n < 18460) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 18460) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic slp(input logic deep);
    deep_sleep_en <= deep;
    wait_irq_req <= 1'b1;
    @(posedge sys_clk);
    wait_irq_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wake;
    irq_pending <= 1'b1;
    repeat (5) @(posedge sys_clk);
    irq_pending <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(pll_pwr_on, 0);
    req(0, `PSG_A_BASE_CFG, 0);
    chk(rd_q, `PSG_RST_BASE_CFG);
    req(0, `PSG_A_EXT_CFG, 0);
    chk(rd_q, `PSG_RST_EXT_CFG);
    req(0, 12'h200, 0);
    chk(rd_q, 0);
    $display("reset test done");
    // one-step enable: extended use, /64, pll normal and selected
    req(1, `PSG_A_EXT_CFG, 32'h9f800000);
    chk(sys_divisor, 7'h40);
    chk(pll_pwr_on, 1);
    chk(sys_use_pll, 0);
    wlock();
    chk(n > 18410, 1);
    repeat (2) @(posedge sys_clk);
    chk(sys_use_pll, 1);
    req(0, `PSG_A_RAW_STAT, 0);
    chk(rd_q & 32'h40, 32'h40);
    $display("relock test done");
    req(0, `PSG_A_TRANSL, 0);
    t0 = rd_q;
    req(1, `PSG_A_BASE_CFG, `PSG_RST_BASE_CFG);
    chk(pll_locked, 1);
    req(1, `PSG_A_BASE_CFG, 32'h07803b91);
    chk(pll_locked, 0);
    req(1, `PSG_A_TRANSL, 0);
    req(0, `PSG_A_TRANSL, 0);
    chk(rd_q, {20'h0, pll_translation});
    chk(rd_q != t0, 1);
    wlock();
    $display("crystal test done");
    req(1, `PSG_A_BASE_CFG, 32'h0f803b91);
    req(1, `PSG_A_RUN_GATE, 32'h00000041);
    req(1, `PSG_A_SLP_GATE, 32'h00000002);
    req(1, `PSG_A_DSLP_GATE, 32'h00000004);
    req(1, `PSG_A_DSLP_CFG, 32'h02800000);
    chk(periph_clk_en, 32'h41);
    slp(0);
    chk(cpu_clk_en, 0);
    chk(sys_divisor, 7'h40);
    chk(periph_clk_en, 32'h02);
    wake();
    chk(periph_clk_en, 32'h41);
    slp(1);
    chk(periph_clk_en, 32'h04);
    chk(sys_src_sel, `PSG_OSC_MAIN);
    chk(main_osc_pwr_on, 1);
    chk(int_osc_pwr_on, 0);
    chk(pll_pwr_on, 0);
    chk(sys_divisor, 7'h06);
    wake();
    chk(sys_divisor, 7'h40);
    chk(cpu_clk_en, 1);
    $display("sleep test done");
    req(1, `PSG_A_EXT_CFG, 32'h9f800070);
    chk(pll_translation, 12'hfff);
    req(1, `PSG_A_EXT_CFG, 32'h9f800800);
    chk(sys_div_en, 0);
    chk(sys_divisor, 7'h01);
    $display("reference test done");
    summarize();
  end
endmodule // test_psg_clock_ctrl
`default_nettype wire
